// [inc/tcsc_pkg.sv]
// Package with constants and carrier types for the tape control status check block.
`default_nettype none
package tcsc_pkg;

  // Control orders issued with a control tag.
  typedef enum logic [2:0] {
    TCSC_ORD_RWD_UNLOAD,
    TCSC_ORD_SET_HIGH_SENSE,
    TCSC_ORD_SET_ALT_DENSITY,
    TCSC_ORD_SET_LOW_SENSE,
    TCSC_ORD_SECURE_ERASE,
    TCSC_ORD_SET_ERASE,
    TCSC_ORD_REWIND,
    TCSC_ORD_GAIN_BURST_LP
  } tcsc_order_t;

  // Response byte bit positions.
  localparam int unsigned TCSC_RSP_RWD_UNLOAD_BIT = 0;
  localparam int unsigned TCSC_RSP_SPARE_BIT      = 1;
  localparam int unsigned TCSC_RSP_HIGH_SENSE_BIT = 2;
  localparam int unsigned TCSC_RSP_ALT_DENS_BIT   = 3;
  localparam int unsigned TCSC_RSP_LOW_SENSE_BIT  = 4;
  localparam int unsigned TCSC_RSP_SEC_ERASE_BIT  = 5;
  localparam int unsigned TCSC_RSP_SET_ERASE_BIT  = 6;
  localparam int unsigned TCSC_RSP_REWIND_BIT     = 7;

  // Special response values.
  localparam logic [7:0] TCSC_RSP_NONE       = 8'h00;
  localparam logic [7:0] TCSC_RSP_GAIN_BURST = 8'h12;
  localparam logic [7:0] TCSC_RSP_THRESH     = 8'h14;

  // Sense byte 10 bit positions and sense byte 10 and 23 reset values.
  localparam int unsigned TCSC_S10_REJECT_BIT   = 2;
  localparam int unsigned TCSC_S10_TURN_ERR_BIT = 4;
  localparam logic [7:0]  TCSC_S10_RESET        = 8'h00;
  localparam logic [7:0]  TCSC_S23_RESET        = 8'h00;

  // Timing: turnaround limit and start-marker search time.
  localparam int unsigned TCSC_CLK_MHZ          = 125;
  localparam int unsigned TCSC_TURN_LIMIT_US    = 20;
  localparam int unsigned TCSC_TURN_LIMIT_CYC   = TCSC_TURN_LIMIT_US * TCSC_CLK_MHZ;
  localparam int unsigned TCSC_MARKER_WAIT_US   = 40;
  localparam int unsigned TCSC_MARKER_WAIT_CYC  = TCSC_MARKER_WAIT_US * TCSC_CLK_MHZ;

  // Order request from the sequencer.
  typedef struct packed {
    logic        valid;
    tcsc_order_t order;
  } tcsc_req_t;

  // Sense output bundle.
  typedef struct packed {
    logic [7:0] byte10;
    logic [7:0] byte23;
  } tcsc_sense_t;

endpackage : tcsc_pkg
`default_nettype wire

// [core/tcsc_expect.sv]
// Expected response pattern lookup and response judgement.
`timescale 1ns/1ns
`default_nettype none
module tcsc_expect (
  // Order and captured response
  input  wire tcsc_pkg::tcsc_order_t i_order,
  input  wire logic [7:0]            i_rsp,
  // Judgement
  output logic                       o_reject
);

  logic [7:0] exp_byte;
  logic [7:0] extra;

  always_comb begin
    exp_byte = tcsc_pkg::TCSC_RSP_NONE;
    unique case (i_order)
      tcsc_pkg::TCSC_ORD_RWD_UNLOAD:     exp_byte[tcsc_pkg::TCSC_RSP_RWD_UNLOAD_BIT] = 1'b1;
      tcsc_pkg::TCSC_ORD_SET_HIGH_SENSE: exp_byte[tcsc_pkg::TCSC_RSP_HIGH_SENSE_BIT] = 1'b1;
      tcsc_pkg::TCSC_ORD_SET_ALT_DENSITY: exp_byte[tcsc_pkg::TCSC_RSP_ALT_DENS_BIT] = 1'b1;
      tcsc_pkg::TCSC_ORD_SET_LOW_SENSE:  exp_byte[tcsc_pkg::TCSC_RSP_LOW_SENSE_BIT] = 1'b1;
      tcsc_pkg::TCSC_ORD_SECURE_ERASE:   exp_byte[tcsc_pkg::TCSC_RSP_SEC_ERASE_BIT] = 1'b1;
      tcsc_pkg::TCSC_ORD_SET_ERASE:      exp_byte[tcsc_pkg::TCSC_RSP_SET_ERASE_BIT] = 1'b1;
      tcsc_pkg::TCSC_ORD_REWIND:         exp_byte[tcsc_pkg::TCSC_RSP_REWIND_BIT] = 1'b1;
      tcsc_pkg::TCSC_ORD_GAIN_BURST_LP:  exp_byte = tcsc_pkg::TCSC_RSP_GAIN_BURST;
    endcase
    // Sense-threshold bits may ride along with the proper answer.
    extra = i_rsp & ~exp_byte;
    if (i_rsp == tcsc_pkg::TCSC_RSP_NONE) begin
      o_reject = 1'b1;
    end else if ((i_rsp & exp_byte) != exp_byte) begin
      o_reject = 1'b1;
    end else begin
      o_reject = |(extra & ~tcsc_pkg::TCSC_RSP_THRESH);
    end
  end

endmodule : tcsc_expect
`default_nettype wire

// [core/tcsc_top.sv]
// Control status check and turnaround supervision for the tape controller.
//
// Function
// - Turnaround counter overflow sets sense 10 bit 4.
// - Reversal only read-to-write or backward-to-forward.
// - Missed start marker after burst sets bit 4; checked in backward read only.
// - Wrong control status sets sense 10 bit 2.
// - Sense byte 23 holds the received response when it is rejected.
// - All-zero response counts as a reject.
// - Value 12 hex valid for gain burst order.
// - Other multi-bit responses rejected, thresholds excepted.
// - Reject may also arise during data commands; here only the answer to a control order is checked.
`timescale 1ns/1ns
`default_nettype none
module tcsc_top #(
  parameter int unsigned TURN_LIMIT_CYC  = tcsc_pkg::TCSC_TURN_LIMIT_CYC,
  parameter int unsigned MARKER_WAIT_CYC = tcsc_pkg::TCSC_MARKER_WAIT_CYC
) (
  // Clock, reset, enable
  input  wire  logic                   i_core_clk,
  input  wire  logic                   i_rst_b,
  input  wire  logic                   i_ce,
  // Control order and unit answer
  input  wire  tcsc_pkg::tcsc_req_t    i_req,
  input  wire  logic                   i_rsp_valid,
  input  wire  logic [7:0]             i_unit_response_byte,
  // Tape motion pins
  input  wire  logic                   i_write_status,
  input  wire  logic                   i_backward,
  input  wire  logic                   i_motion_reversed,
  input  wire  logic                   i_gain_setup_burst,
  input  wire  logic                   i_tape_start_marker,
  // Sense control
  input  wire  logic                   i_sense_reset,
  // Sense and status
  output logic [7:0]                   o_sense_byte10,
  output logic [7:0]                   o_sense_byte23,
  output logic                         o_reversal_busy
);

  localparam int unsigned CW = 32;
  // Pin slots in the synchroniser bank.
  localparam int unsigned NPIN    = 5;
  localparam int unsigned PIN_WR  = 0;
  localparam int unsigned PIN_BK  = 1;
  localparam int unsigned PIN_REV = 2;
  localparam int unsigned PIN_BST = 3;
  localparam int unsigned PIN_MRK = 4;


  typedef enum logic [1:0] {
    TCSC_IDLE,
    TCSC_AWAIT_RSP
  } tcsc_ord_st_t;

  typedef struct packed {
    tcsc_ord_st_t         ord_st;
    tcsc_pkg::tcsc_order_t order;
    logic [NPIN-1:0]      sync0;
    logic [NPIN-1:0]      sync1;
    logic [NPIN-1:0]      sync2;
    logic [NPIN-1:0]      pin_q;
    logic                 rev_busy;
    logic [CW-1:0]        rev_cnt;
    logic                 mark_busy;
    logic [CW-1:0]        mark_cnt;
    tcsc_pkg::tcsc_sense_t sense;
  } tcsc_state_t;

  tcsc_state_t state_ff;
  tcsc_state_t nxt_state;
  logic        rsp_reject;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_lvl;

  // Every state bit has a known value after reset; the pin history starts at the idle low level.
  localparam tcsc_state_t ST_RESET = '{
    ord_st:    TCSC_IDLE,
    order:     tcsc_pkg::TCSC_ORD_RWD_UNLOAD,
    sync0:     '0,
    sync1:     '0,
    sync2:     '0,
    pin_q:     '0,
    rev_busy:  1'b0,
    rev_cnt:   '0,
    mark_busy: 1'b0,
    mark_cnt:  '0,
    sense:     '{byte10: tcsc_pkg::TCSC_S10_RESET, byte23: tcsc_pkg::TCSC_S23_RESET}
  };

  // Pin order in the bank follows the slot numbers above.
  assign pin_raw = {i_tape_start_marker,
                    i_gain_setup_burst,
                    i_motion_reversed,
                    i_backward,
                    i_write_status};

  // A level moves only when the last two stages agree, so a single unsettled sample never counts.
  for (genvar k = 0; k < NPIN; k++) begin : g_pin
    assign pin_lvl[k] = (state_ff.sync2[k] == state_ff.sync1[k]) ? state_ff.sync2[k] : state_ff.pin_q[k];
  end

  tcsc_expect u_expect (
    .i_order  (state_ff.order),
    .i_rsp    (i_unit_response_byte),
    .o_reject (rsp_reject)
  );

  // Decoded pin levels and timer events.
  logic wr_now;
  logic bk_now;
  logic rev_now;
  logic burst_now;
  logic mark_now;
  logic burst_seen;
  logic rev_start;
  logic rev_over;
  logic mark_over;

  always_comb begin
    nxt_state = state_ff;
    // Pins pass three flops before anything reads them.
    nxt_state.sync0 = pin_raw;
    nxt_state.sync1 = state_ff.sync0;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.pin_q = pin_lvl;
    wr_now     = pin_lvl[PIN_WR];
    bk_now     = pin_lvl[PIN_BK];
    rev_now    = pin_lvl[PIN_REV];
    burst_now  = pin_lvl[PIN_BST];
    mark_now   = pin_lvl[PIN_MRK];
    burst_seen = 1'b0;
    // Read-to-write or backward-to-forward, taken from the filtered levels.
    rev_start  = (wr_now & ~state_ff.pin_q[PIN_WR]) | (~bk_now & state_ff.pin_q[PIN_BK]);
    // Counters stop one short of the limit, so the overflow lands on the limit's own cycle.
    rev_over   = state_ff.rev_cnt >= CW'(TURN_LIMIT_CYC - 1);
    mark_over  = state_ff.mark_cnt >= CW'(MARKER_WAIT_CYC - 1);

    if (i_sense_reset) begin
      nxt_state.sense.byte10 = tcsc_pkg::TCSC_S10_RESET;
      nxt_state.sense.byte23 = tcsc_pkg::TCSC_S23_RESET;
    end

    // Reversal starts only on read-to-write or backward-to-forward.
    if (rev_start) begin
      nxt_state.rev_busy = 1'b1;
      nxt_state.rev_cnt  = '0;
    end else if (state_ff.rev_busy) begin
      if (rev_now) begin
        nxt_state.rev_busy = 1'b0;
      end else if (rev_over) begin
        nxt_state.rev_busy = 1'b0;
        nxt_state.sense.byte10[tcsc_pkg::TCSC_S10_TURN_ERR_BIT] = 1'b1;
      end else begin
        nxt_state.rev_cnt = state_ff.rev_cnt + CW'(1);
      end
    end

    // Backward read: the start marker must follow the burst in time.
    // Leaving backward motion cancels the wait, since the marker can no longer come.
    burst_seen = burst_now & bk_now & ~wr_now;
    if (burst_seen & ~state_ff.mark_busy) begin
      nxt_state.mark_busy = 1'b1;
      nxt_state.mark_cnt  = '0;
    end else if (state_ff.mark_busy) begin
      if (mark_now | ~bk_now) begin
        nxt_state.mark_busy = 1'b0;
      end else if (mark_over) begin
        nxt_state.mark_busy = 1'b0;
        nxt_state.sense.byte10[tcsc_pkg::TCSC_S10_TURN_ERR_BIT] = 1'b1;
      end else begin
        nxt_state.mark_cnt = state_ff.mark_cnt + CW'(1);
      end
    end

    // Order sequencing; the check runs only on the answer to a latched control order.
    unique case (state_ff.ord_st)
      TCSC_IDLE: begin
        if (i_req.valid) begin
          nxt_state.order  = i_req.order;
          nxt_state.ord_st = TCSC_AWAIT_RSP;
        end
      end
      TCSC_AWAIT_RSP: begin
        if (i_rsp_valid) begin
          nxt_state.ord_st = TCSC_IDLE;
          if (rsp_reject) begin
            nxt_state.sense.byte10[tcsc_pkg::TCSC_S10_REJECT_BIT] = 1'b1;
            nxt_state.sense.byte23 = i_unit_response_byte;
          end
        end
      end
      default: begin
        nxt_state.ord_st = TCSC_IDLE;
      end
    endcase
  end

  // A low enable holds every bit, the timers included, so a paused block loses no time.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= ST_RESET;
    end else if (i_ce) begin
      state_ff <= nxt_state;
    end
  end

  // Outputs come straight from the state register.
  assign o_sense_byte10  = state_ff.sense.byte10;
  assign o_sense_byte23  = state_ff.sense.byte23;
  assign o_reversal_busy = state_ff.rev_busy;

endmodule : tcsc_top
`default_nettype wire

// [bench/tcsc_chk.sv]
// Concurrent checks on the ports of the tape control status check block.
`timescale 1ns/1ns
`default_nettype none
module tcsc_chk #(
  parameter int unsigned TURN_LIMIT_CYC = 8
) (
  // Clock, reset, enable
  input wire logic                i_core_clk,
  input wire logic                i_rst_b,
  input wire logic                i_ce,
  // Order path and sense control
  input wire tcsc_pkg::tcsc_req_t i_req,
  input wire logic                i_rsp_valid,
  input wire logic [7:0]          i_unit_response_byte,
  input wire logic                i_sense_reset,
  // Watched outputs
  input wire logic [7:0]          o_sense_byte10,
  input wire logic [7:0]          o_sense_byte23,
  input wire logic                o_reversal_busy
);
  logic        pend_ff;
  logic [2:0]  ord_ff;
  logic [7:0]  last_ff;
  int unsigned busy_ff;
  logic [7:0]  want;
  logic        ok_w;
  // Threshold bits 2 and 4 may ride along with any answer, so they are masked out.
  always_comb begin
    want = (ord_ff == 3'h7) ? 8'h12 : (ord_ff == 3'h0) ? 8'h01 : 8'h01 << (ord_ff + 3'h1);
    ok_w = ((i_unit_response_byte & want) == want) && ((i_unit_response_byte & ~(want | 8'h14)) == 8'h00);
  end
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_ff <= 1'b0;
      ord_ff  <= 3'h0;
      last_ff <= 8'h00;
      busy_ff <= 0;
    end else if (i_ce) begin
      if (!pend_ff && i_req.valid) begin
        pend_ff <= 1'b1;
        ord_ff  <= i_req.order;
      end else if (pend_ff && i_rsp_valid) begin
        pend_ff <= 1'b0;
        last_ff <= i_unit_response_byte;
      end
      busy_ff <= o_reversal_busy ? busy_ff + 1 : 0;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_take;
    pend_ff && i_ce && i_rsp_valid;
  endsequence
  a_bad_reject: assert property (s_take ##0 !ok_w |-> ##[1:2] o_sense_byte10[2])
    else $error("reject bit missing after wrong answer");
  a_zero_reject: assert property (s_take ##0 (i_unit_response_byte == 8'h00) |-> ##[1:2] o_sense_byte10[2])
    else $error("reject bit missing after empty answer");
  a_spare_reject: assert property (s_take ##0 (i_unit_response_byte[1] && ord_ff != 3'h7) |-> ##[1:2] o_sense_byte10[2])
    else $error("reject bit missing after spare bit");
  a_good_quiet: assert property (s_take ##0 (ok_w && !o_sense_byte10[2]) |=> !o_sense_byte10[2] [*2])
    else $error("reject raised on a correct answer");
  a_reject_copy: assert property ($rose(o_sense_byte10[2]) |-> o_sense_byte23 == last_ff)
    else $error("sense byte 23 differs from the answer");
  a_turn_sticky: assert property (o_sense_byte10[4] && !i_sense_reset |=> o_sense_byte10[4])
    else $error("turnaround error bit lost");
  a_turn_overflow: assert property (busy_ff == TURN_LIMIT_CYC |-> ##[0:2] o_sense_byte10[4])
    else $error("turnaround overflow not flagged");
  a_sense_clear: assert property (i_ce && i_sense_reset && !i_rsp_valid && !$past(i_rsp_valid) |=> o_sense_byte23 == 8'h00)
    else $error("sense byte 23 not cleared");
endmodule : tcsc_chk
bind tcsc_top tcsc_chk #(.TURN_LIMIT_CYC(TURN_LIMIT_CYC)) u_chk (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_ce(i_ce), .i_req(i_req), .i_rsp_valid(i_rsp_valid), .i_unit_response_byte(i_unit_response_byte),
  .i_sense_reset(i_sense_reset), .o_sense_byte10(o_sense_byte10), .o_sense_byte23(o_sense_byte23),
  .o_reversal_busy(o_reversal_busy));
`default_nettype wire

// [bench/tcsc_unit_model.sv]
// Behavioural tape unit answering control orders on its inbound bus.
`timescale 1ns/1ns
`default_nettype none
module tcsc_unit_model (
  // Clock and order
  input  wire logic                i_core_clk,
  input  wire tcsc_pkg::tcsc_req_t i_req,
  // Answer style and latency from the bench
  input  wire logic [2:0]          i_fault,
  input  wire logic [1:0]          i_delay,
  // Inbound bus
  output var  logic                o_rsp_valid = 1'b0,
  output var  logic [7:0]          o_rsp = 8'h5A
);
  logic [7:0] ans;
  int         cnt = 0;
  always @(posedge i_core_clk) begin
    if (cnt == 1) begin
      o_rsp_valid <= 1'b1;
      o_rsp       <= ans;
    end else begin
      o_rsp_valid <= 1'b0;
      // Between answers the bus toggles, so a stale byte never passes for an answer.
      o_rsp       <= ~o_rsp;
    end
    if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (i_req.valid) begin
      ans = (i_req.order == 3'h7) ? 8'h12 : (i_req.order == 3'h0) ? 8'h01 : 8'h01 << (i_req.order + 3'h1);
      // Bit 1 is driven in the gain-burst answer and when the bench asks for fault 2.
      ans = (i_fault == 3'h1) ? 8'h00 : (i_fault == 3'h2) ? ans | 8'h02 : (i_fault == 3'h3) ? ans | 8'h14 :
            (i_fault == 3'h4) ? ans ^ 8'h81 : ans;
      cnt <= i_delay + 1;
    end
  end
endmodule : tcsc_unit_model
`default_nettype wire

// [bench/tcsc_top_tb.sv]
// Self-checking testbench for the tape control status check block.
`timescale 1ns/1ns
`default_nettype none
module tcsc_top_tb;
  logic                clk = 1'b0;
  logic                rst_b = 1'b0;
  tcsc_pkg::tcsc_req_t req = '0;
  logic                wr = 1'b0, bk = 1'b0, rev = 1'b0, brst = 1'b0, mark = 1'b0, srst = 1'b0;
  logic                rsp_v, busy;
  logic [7:0]          rsp, s10, s23;
  logic [2:0]          fault = 3'h0;
  logic [1:0]          dly = 2'h0;
  logic                ce = 1'b1;
  int                  mismatches = 0;
  int                  comparisons = 0;
  int                  seed;
  always #4 clk = ~clk;
  tcsc_top #(.TURN_LIMIT_CYC(8), .MARKER_WAIT_CYC(16)) dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_ce(ce),
    .i_req(req), .i_rsp_valid(rsp_v), .i_unit_response_byte(rsp), .i_write_status(wr), .i_backward(bk),
    .i_motion_reversed(rev), .i_gain_setup_burst(brst), .i_tape_start_marker(mark), .i_sense_reset(srst),
    .o_sense_byte10(s10), .o_sense_byte23(s23), .o_reversal_busy(busy));
  tcsc_unit_model u_unit (.i_core_clk(clk), .i_req(req), .i_fault(fault), .i_delay(dly), .o_rsp_valid(rsp_v),
    .o_rsp(rsp));
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic clr;
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    step(2);
  endtask : clr
  function automatic logic [7:0] exp_rsp(input logic [2:0] o, input logic [2:0] f);
    logic [7:0] w;
    w = (o == 3'h7) ? 8'h12 : (o == 3'h0) ? 8'h01 : 8'h01 << (o + 3'h1);
    return (f == 3'h1) ? 8'h00 : (f == 3'h2) ? w | 8'h02 : (f == 3'h3) ? w | 8'h14 : (f == 3'h4) ? w ^ 8'h81 : w;
  endfunction : exp_rsp
  // An answer is judged against the clean answer for its order; bits 2 and 4 may ride along.
  function automatic logic exp_rej(input logic [2:0] o, input logic [2:0] f);
    logic [7:0] r;
    logic [7:0] w;
    r = exp_rsp(o, f);
    w = exp_rsp(o, 3'h0);
    return (r == 8'h00) || ((r & w) != w) || ((r & ~(w | 8'h14)) != 8'h00);
  endfunction : exp_rej
  task automatic ctl(input logic [2:0] o, input logic [2:0] f);
    logic rej;
    rej = exp_rej(o, f);
    @(posedge clk) begin
      fault <= f;
      dly   <= 2'($urandom_range(3));
      req   <= '{1'b1, tcsc_pkg::tcsc_order_t'(o)};
    end
    @(posedge clk) req.valid <= 1'b0;
    step(8);
    chk({7'h00, s10[2]}, {7'h00, rej});
    chk(s23, rej ? exp_rsp(o, f) : 8'h00);
    clr;
  endtask : ctl
  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  initial begin
    seed = $urandom(32'hD4896A32);
    step(5);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) ctl(3'(i), 3'h0);
    for (int i = 1; i < 5; i++) ctl(3'(i + 3), 3'(i));
    // Bit 1 already belongs to the gain-burst answer, so adding it leaves a valid byte.
    ctl(3'h7, 3'h2);
    repeat (20) ctl(3'($urandom_range(7)), 3'($urandom_range(4)));
    $display("Control order tests done");
    @(posedge clk) wr <= 1'b1;
    step(8);
    chk({7'h00, busy}, 8'h01);
    step(12);
    chk(s10, 8'h10);
    // With the enable low a sense reset must not reach the sticky bit.
    @(posedge clk) begin
      ce   <= 1'b0;
      srst <= 1'b1;
    end
    @(posedge clk) srst <= 1'b0;
    step(2);
    chk(s10, 8'h10);
    @(posedge clk) ce <= 1'b1;
    clr;
    @(posedge clk) begin
      wr <= 1'b0;
      bk <= 1'b1;
    end
    step(20);
    chk(s10 | {7'h00, busy}, 8'h00);
    // The burst must outlast the pin filter, which drops a single-cycle blip.
    @(posedge clk) brst <= 1'b1;
    step(2);
    @(posedge clk) brst <= 1'b0;
    step(30);
    chk(s10, 8'h10);
    clr;
    // The start marker stays seen, so leaving backward must end cleanly once motion reverses.
    @(posedge clk) mark <= 1'b1;
    @(posedge clk) bk <= 1'b0;
    step(2);
    @(posedge clk) rev <= 1'b1;
    step(20);
    chk(s10 | {7'h00, busy}, 8'h00);
    $display("Motion tests done");
    conclude;
  end
  initial begin
    step(3000);
    mismatches++;
    conclude;
  end
endmodule : tcsc_top_tb
`default_nettype wire
